// ### hw/uart_core.v
// Purpose: Serial port core, modes 0 and 1, baud generation.
// Assumes: clk is the CPU clock; one clk per machine state.
// Notes:   Modes 2 and 3 use the 10-bit frame engine.
//
// The APB register port and the address map were decided locally.
`include "uart_regs.vh"
module uart_core (
    input  wire        clk,            // CPU clock
    input  wire        sys_rst,        // Sync reset, high
    input  wire        psel,           // APB select
    input  wire        penable,        // APB enable
    input  wire        pwrite,         // APB write
    input  wire [7:0]  paddr,          // APB byte address
    input  wire [31:0] pwdata,         // APB write data
    output reg  [31:0] prdata,         // APB read data
    output reg         pready,         // APB ready
    output reg         pslverr,        // APB error
    input  wire        serial_in_pin,  // Data pin level in
    output reg         serial_in_out,  // Data pin drive value
    output reg         serial_in_oe_n, // Data pin drive, low
    output reg         serial_out_pin  // Tx data or shift clock
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg  [1:0] mode;
    reg        multiproc_filter_bit;
    reg        receive_enable_bit;
    reg        tx_ninth;
    reg        rx_ninth_bit;
    reg        tx_done_flag;
    reg        rx_done_flag;
    reg        baud_double_sel;
    reg  [7:0] reload;
    reg  [7:0] rx_buf;
    reg  [2:0] phase;
    reg  [7:0] tmr;
    reg        t1_ovf;
    reg        ovf_half;
    reg        div2;
    reg  [3:0] tx_cnt;
    reg  [8:0] tx_sr;
    reg        tx_req;
    reg        tx_wait;
    reg        tx_active;
    reg        tx_data;
    reg        rx0_wait;
    reg        rx_active;
    reg  [7:0] rx0_sr;
    reg        rx0_samp;
    reg        rx_busy;
    reg        rx_first;
    reg  [3:0] rx_cnt;
    reg  [8:0] rx_sr;
    reg        vote_a;
    reg        vote_b;
    reg        vote;
    reg        pin_meta;
    reg        pin_s;
    reg        pin_prev;
    reg        next_out;
    reg [31:0] next_rdata;
    reg        next_err;
    wire       m0;
    wire       mc_end;
    wire       tick16;
    wire       tx_roll;
    wire       acc;
    wire       wr;
    wire       wr_ctl;
    wire       wr_buf;
    wire       tx_step;
    wire       tx_end;
    wire       rx0_final;
    wire       rx1_final;
    wire       rx1_load;
    wire       sclk;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign acc    = psel & penable & pready;
    assign wr     = acc & pwrite;
    assign wr_ctl = wr & (paddr == `OFS_CTRL);
    assign wr_buf = wr & (paddr == `OFS_BUF);

    // Read mux for the setup cycle
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (paddr)
            `OFS_CTRL:   next_rdata[7:0] = {mode, multiproc_filter_bit, receive_enable_bit,
                                            tx_ninth, rx_ninth_bit, tx_done_flag, rx_done_flag};
            `OFS_BUF:    next_rdata[7:0] = rx_buf;
            `OFS_PWR:    next_rdata[`PWR_DOUBLE] = baud_double_sel;
            `OFS_RELOAD: next_rdata[7:0] = reload;
            default:     next_err = 1'b1;
        endcase
    end

    // APB slave answer, one access cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= next_err;
            prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------
    // Machine cycle and baud generation
    // ----------------------------------------
    assign m0     = (mode == 2'd0);
    assign mc_end = (phase == `MC_LAST);

    // Six states per machine cycle, one bit each in mode 0
    always @(posedge clk) begin
        if (sys_rst)
            phase <= 3'd0;
        else if (mc_end)
            phase <= 3'd0;
        else
            phase <= phase + 3'd1;
    end

    // Auto-reload timer counting machine cycles
    always @(posedge clk) begin
        if (sys_rst) begin
            tmr      <= `RELOAD_RST;
            t1_ovf   <= 1'b0;
            ovf_half <= 1'b0;
            div2     <= 1'b0;
        end else begin
            div2   <= ~div2;
            t1_ovf <= 1'b0;
            if (mc_end) begin
                if (tmr == 8'hFF) begin
                    tmr    <= reload;
                    t1_ovf <= 1'b1;
                end else begin
                    tmr <= tmr + 8'd1;
                end
            end
            if (t1_ovf)
                ovf_half <= ~ovf_half;
        end
    end

    // 16x sample tick per mode
    assign tick16 = (mode == 2'd2) ? (baud_double_sel | div2) :
                    (t1_ovf & (baud_double_sel | ovf_half));

    // Transmit divide-by-16 counter
    always @(posedge clk) begin
        if (sys_rst)
            tx_cnt <= 4'h0;
        else if (tick16)
            tx_cnt <= tx_cnt + 4'h1;
    end
    assign tx_roll = tick16 & (tx_cnt == `BIT_LAST);

    // ----------------------------------------
    // Control registers and flags
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            {mode, multiproc_filter_bit, receive_enable_bit, tx_ninth,
             rx_ninth_bit, tx_done_flag, rx_done_flag} <= `CTRL_RST;
            baud_double_sel <= 1'b0;
            reload          <= `RELOAD_RST;
            rx_buf          <= 8'h00;
        end else begin
            if (wr_ctl) begin
                mode                 <= pwdata[`CTL_MODE_HI:`CTL_MODE_LO];
                multiproc_filter_bit <= pwdata[`CTL_FILTER];
                receive_enable_bit   <= pwdata[`CTL_REN];
                tx_ninth             <= pwdata[`CTL_TX_NINTH];
                rx_ninth_bit         <= pwdata[`CTL_RX_NINTH];
                tx_done_flag         <= pwdata[`CTL_TX_DONE];
                rx_done_flag         <= pwdata[`CTL_RX_DONE];
            end
            if (wr && paddr == `OFS_PWR)
                baud_double_sel <= pwdata[`PWR_DOUBLE];
            if (wr && paddr == `OFS_RELOAD)
                reload <= pwdata[7:0];
            // Hardware set wins over a software clear
            if (tx_end)
                tx_done_flag <= 1'b1;
            if (rx0_final) begin
                rx_buf       <= {rx0_samp, rev7(rx0_sr[6:0])};
                rx_done_flag <= 1'b1;
            end
            if (rx1_load) begin
                rx_buf       <= rx_sr[8:1];
                rx_ninth_bit <= vote;
                rx_done_flag <= 1'b1;
            end
        end
    end

    // Mode 0 bits enter at bit 0 and move up: first bit ends highest
    function [6:0] rev7;
        input [6:0] v;
        begin
            rev7 = {v[0], v[1], v[2], v[3], v[4], v[5], v[6]};
        end
    endfunction

    // ----------------------------------------
    // Transmit engine
    // ----------------------------------------
    assign tx_step = m0 ? mc_end : tx_roll;
    assign tx_end  = tx_step & tx_active & (m0 | tx_data) &
                     (tx_sr[8:1] == `TX_MARKER);

    always @(posedge clk) begin
        if (sys_rst) begin
            tx_sr     <= 9'h000;
            tx_req    <= 1'b0;
            tx_wait   <= 1'b0;
            tx_active <= 1'b0;
            tx_data   <= 1'b0;
        end else if (wr_buf) begin
            tx_sr     <= {1'b1, pwdata[7:0]};
            tx_wait   <= m0;
            tx_req    <= ~m0;
            tx_active <= 1'b0;
            tx_data   <= 1'b0;
        end else if (tx_step) begin
            if (tx_wait) begin
                tx_wait   <= 1'b0;
                tx_active <= 1'b1;
            end else if (tx_req) begin
                tx_req    <= 1'b0;
                tx_active <= 1'b1;
            end else if (tx_active && !m0 && !tx_data) begin
                tx_data <= 1'b1;
            end else if (tx_active) begin
                tx_sr <= {1'b0, tx_sr[8:1]};
                if (tx_end) begin
                    tx_active <= 1'b0;
                    tx_data   <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Mode 0 receive engine
    // ----------------------------------------
    assign rx0_final = m0 & mc_end & rx_active & ~rx0_sr[7];

    always @(posedge clk) begin
        if (sys_rst) begin
            rx0_wait  <= 1'b0;
            rx_active <= 1'b0;
            rx0_sr    <= 8'h00;
            rx0_samp  <= 1'b0;
        end else if (!m0) begin
            rx0_wait  <= 1'b0;
            rx_active <= 1'b0;
        end else begin
            if (phase == `MC_SAMPLE)
                rx0_samp <= pin_s;
            if (!rx0_wait && !rx_active && receive_enable_bit && !rx_done_flag)
                rx0_wait <= 1'b1;
            if (mc_end && rx0_wait) begin
                rx0_wait  <= 1'b0;
                rx0_sr    <= `RX0_INIT;
                rx_active <= 1'b1;
            end else if (mc_end && rx_active) begin
                rx0_sr <= {rx0_sr[6:0], rx0_samp};
                if (rx0_final)
                    rx_active <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Mode 1 receive engine
    // ----------------------------------------
    assign rx1_final = ~m0 & tick16 & rx_busy & ~rx_first &
                       (rx_cnt == `BIT_LAST) & ~rx_sr[0];
    assign rx1_load  = rx1_final & ~rx_done_flag &
                       (~multiproc_filter_bit | vote);

    always @(posedge clk) begin
        if (sys_rst) begin
            rx_busy  <= 1'b0;
            rx_first <= 1'b0;
            rx_cnt   <= 4'h0;
            rx_sr    <= 9'h000;
            vote_a   <= 1'b0;
            vote_b   <= 1'b0;
            vote     <= 1'b0;
            pin_prev <= 1'b1;
        end else if (m0) begin
            rx_busy <= 1'b0;
        end else if (tick16) begin
            pin_prev <= pin_s;
            if (!rx_busy) begin
                if (receive_enable_bit && pin_prev && !pin_s) begin
                    rx_busy  <= 1'b1;
                    rx_first <= 1'b1;
                    rx_cnt   <= 4'h0;
                    rx_sr    <= `RX1_INIT;
                end
            end else begin
                rx_cnt <= rx_cnt + 4'h1;
                case (rx_cnt)
                    `SMP_A:  vote_a <= pin_s;
                    `SMP_B:  vote_b <= pin_s;
                    `SMP_C:  vote   <= (vote_a & vote_b) | (vote_a & pin_s) | (vote_b & pin_s);
                    `BIT_LAST: begin
                        rx_first <= 1'b0;
                        if (rx_first && vote)
                            rx_busy <= 1'b0;
                        else
                            rx_sr <= {vote, rx_sr[8:1]};
                        if (rx1_final)
                            rx_busy <= 1'b0;
                    end
                    default: rx_cnt <= rx_cnt + 4'h1;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    // Two-stage synchroniser for the data pin
    always @(posedge clk) begin
        if (sys_rst) begin
            pin_meta <= 1'b1;
            pin_s    <= 1'b1;
        end else begin
            pin_meta <= serial_in_pin;
            pin_s    <= pin_meta;
        end
    end

    // Shift clock low in S3 to S5
    assign sclk = ~((phase >= `MC_SCLK_LO) && (phase <= `MC_SCLK_HI));

    // Output selection
    always @* begin
        if (m0)
            next_out = (tx_active | rx_active) ? sclk : 1'b1;
        else if (tx_active)
            next_out = tx_data ? tx_sr[0] : 1'b0;
        else
            next_out = 1'b1;
    end

    // Registered pin drive
    always @(posedge clk) begin
        if (sys_rst) begin
            serial_out_pin <= 1'b1;
            serial_in_out  <= 1'b1;
            serial_in_oe_n <= 1'b1;
        end else begin
            serial_out_pin <= next_out;
            serial_in_out  <= tx_sr[0];
            serial_in_oe_n <= ~(m0 & tx_active);
        end
    end
endmodule // uart_core

// ### hw/uart_regs.vh
// Purpose: Constants for the serial port core.
// Assumes: 32-bit APB, one register per aligned word.
// Notes:   Offsets are byte addresses.
`ifndef UART_REGS_VH
`define UART_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CTRL   8'h00
`define OFS_BUF    8'h04
`define OFS_PWR    8'h08
`define OFS_RELOAD 8'h0C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTL_MODE_HI 7
`define CTL_MODE_LO 6
`define CTL_FILTER  5
`define CTL_REN     4
`define CTL_TX_NINTH 3
`define CTL_RX_NINTH 2
`define CTL_TX_DONE  1
`define CTL_RX_DONE  0
`define PWR_DOUBLE  7
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CTRL_RST    8'h00
`define RELOAD_RST  8'h00
`define MC_LAST     3'd5
`define MC_SCLK_LO  3'd2
`define MC_SCLK_HI  3'd4
`define MC_SAMPLE   3'd4
`define BIT_LAST    4'hF
`define SMP_A       4'h7
`define SMP_B       4'h8
`define SMP_C       4'h9
`define TX_MARKER   8'h01
`define RX0_INIT    8'hFE
`define RX1_INIT    9'h1FF
`endif

// ### test/serial_peer.sv
// Purpose: Far-side serial peer for modes 0 and 1.
// Assumes: Released data pin is pulled up.
// Notes:   Tasks are called by the bench after a clock edge.
module serial_peer (
    input  wire logic clk,       // CPU clock
    input  wire logic shift_clk, // Core shift clock or tx line
    input  wire logic line,      // Resolved data pin
    input  wire logic core_oe_n, // Core drives data pin, low
    output logic      drv,       // Peer drive value
    output logic      drv_oe_n   // Peer drives data pin, low
);
    timeunit 1ns;
    timeprecision 1ns;
    int         bit_clks = 96;
    int         cnt = 0;
    logic [7:0] cap = 8'h00;
    logic [7:0] shf = 8'h00;
    logic       m0_src = 1'b0;
    initial begin
        drv = 1'b1;
        drv_oe_n = 1'b1;
    end

    // Take core bits on clock fall, LSB first
    always @(negedge shift_clk) begin
        if (!core_oe_n && cnt < 8) begin
            cap <= {line, cap[7:1]};
            cnt <= cnt + 1;
        end
    end

    // Offer next bit after each clock rise
    always @(posedge shift_clk) begin
        if (m0_src) begin
            drv <= shf[1];
            shf <= shf >> 1;
        end
    end

    task automatic m0_load(input logic [7:0] b);
        shf <= b;
        drv <= b[0];
        drv_oe_n <= 1'b0;
        m0_src <= 1'b1;
    endtask

    task automatic m0_free;
        m0_src <= 1'b0;
        drv_oe_n <= 1'b1;
        drv <= 1'b1;
        cnt <= 0;
    endtask

    // Start, data LSB first, stop
    task automatic send1(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        drv_oe_n <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            drv <= f[i];
            repeat (bit_clks) @(posedge clk);
        end
        drv <= 1'b1;
        drv_oe_n <= 1'b1;
    endtask

    // Short low pulse, not a start bit
    task automatic glitch;
        drv_oe_n <= 1'b0;
        drv <= 1'b0;
        repeat (bit_clks / 4) @(posedge clk);
        drv <= 1'b1;
        drv_oe_n <= 1'b1;
    endtask

    task automatic recv1(output logic [7:0] b, output logic stop, output logic ok);
        int n;
        b = 8'h00;
        stop = 1'b0;
        ok = 1'b0;
        for (n = 0; n < 5000 && shift_clk !== 1'b0; n++) @(posedge clk);
        repeat (bit_clks / 2) @(posedge clk);
        ok = (n < 5000) && (shift_clk === 1'b0);
        for (n = 0; n < 8; n++) begin
            repeat (bit_clks) @(posedge clk);
            b[n] = shift_clk;
        end
        repeat (bit_clks) @(posedge clk);
        stop = shift_clk;
    endtask
endmodule // serial_peer

// ### test/tb_top.sv
// Purpose: Self-checking bench for the serial port core.
// Assumes: APB master, 50 MHz clock, peer model.
// Notes:   Mode 1 uses timer reload 8'hFF.
`include "uart_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdv;
    logic        pready, pslverr, err, pin_out, pin_oe_n, sclk, line, drv, drv_oe_n, stop, ok;
    logic [7:0]  rb;
    int          fail_count = 0, num_checks = 0;

    // Data pin: core, else peer, else pull-up
    assign line = !pin_oe_n ? pin_out : (!drv_oe_n ? drv : 1'b1);
    always #10 clk = ~clk;

    uart_core u_uart_core (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_in_pin(line), .serial_in_out(pin_out), .serial_in_oe_n(pin_oe_n), .serial_out_pin(sclk));
    serial_peer u_serial_peer (.clk(clk), .shift_clk(sclk), .line(line), .core_oe_n(pin_oe_n),
        .drv(drv), .drv_oe_n(drv_oe_n));

    task automatic conclude;
        if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, held until ready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            conclude();
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdv & mask, exp);
    endtask

    // Poll a control flag, bounded
    task automatic wflag(input int b);
        int n;
        for (n = 0; n < 2000; n++) begin
            apb(1'b0, `OFS_CTRL, 32'h0000_0000);
            if (rdv[b] === 1'b1) break;
        end
        if (n == 2000) begin
            fail_count++;
            conclude();
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        conclude();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rc(`OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
        rc(`OFS_PWR, 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        // Mode 0 send
        u_serial_peer.m0_free();
        apb(1'b1, `OFS_CTRL, 32'h0000_0000);
        apb(1'b1, `OFS_BUF, 32'h0000_00A5);
        wflag(`CTL_TX_DONE);
        chk({24'h0, u_serial_peer.cap}, 32'h0000_00A5);
        // Mode 0 receive
        u_serial_peer.m0_load(8'h3C);
        apb(1'b1, `OFS_CTRL, 32'h0000_0010);
        wflag(`CTL_RX_DONE);
        rc(`OFS_BUF, 32'h0000_00FF, 32'h0000_003C);
        u_serial_peer.m0_free();
        // Mode 1 send at undoubled rate
        apb(1'b1, `OFS_PWR, 32'h0000_0000);
        apb(1'b1, `OFS_RELOAD, 32'h0000_00FF);
        apb(1'b1, `OFS_CTRL, 32'h0000_0040);
        u_serial_peer.bit_clks = 192;
        fork
            apb(1'b1, `OFS_BUF, 32'h0000_0096);
            u_serial_peer.recv1(rb, stop, ok);
        join
        chk({22'h0, ok, stop, rb}, 32'h0000_0396);
        wflag(`CTL_TX_DONE);
        // Mode 1 receive at doubled rate
        apb(1'b1, `OFS_PWR, 32'h0000_0080);
        apb(1'b1, `OFS_CTRL, 32'h0000_0050);
        u_serial_peer.bit_clks = 96;
        u_serial_peer.send1(8'h5A, 1'b1);
        wflag(`CTL_RX_DONE);
        rc(`OFS_BUF, 32'h0000_00FF, 32'h0000_005A);
        rc(`OFS_CTRL, 32'h0000_0005, 32'h0000_0005);
        // Frame while flag set is lost
        u_serial_peer.send1(8'h33, 1'b1);
        repeat (192) @(posedge clk);
        rc(`OFS_BUF, 32'h0000_00FF, 32'h0000_005A);
        // Filter drops bad stop; idle gap, then a glitch with its own edge
        apb(1'b1, `OFS_CTRL, 32'h0000_0070);
        u_serial_peer.send1(8'h44, 1'b0);
        repeat (192) @(posedge clk);
        u_serial_peer.glitch();
        repeat (1920) @(posedge clk);
        rc(`OFS_CTRL, 32'h0000_0001, 32'h0000_0000);
        u_serial_peer.send1(8'hC3, 1'b1);
        wflag(`CTL_RX_DONE);
        rc(`OFS_BUF, 32'h0000_00FF, 32'h0000_00C3);
        // Mode 2 send at doubled fixed rate, sixteen clocks a bit
        apb(1'b1, `OFS_CTRL, 32'h0000_0080);
        u_serial_peer.bit_clks = 16;
        fork
            apb(1'b1, `OFS_BUF, 32'h0000_0069);
            u_serial_peer.recv1(rb, stop, ok);
        join
        chk({22'h0, ok, stop, rb}, 32'h0000_0369);
        conclude();
    end
endmodule // tb_top

// ### test/uart_core_sva.sv
// Purpose: Port checks for the serial port core.
// Assumes: One clock domain, sync reset high.
// Notes:   Bound to every uart_core instance.
module uart_core_sva (
    input wire logic        clk,            // CPU clock
    input wire logic        sys_rst,        // Sync reset
    input wire logic        psel,           // APB select
    input wire logic        penable,        // APB enable
    input wire logic        pwrite,         // APB write
    input wire logic [7:0]  paddr,          // APB address
    input wire logic [31:0] pwdata,         // APB write data
    input wire logic [31:0] prdata,         // APB read data
    input wire logic        pready,         // APB ready
    input wire logic        pslverr,        // APB error
    input wire logic        serial_in_pin,  // Data pin in
    input wire logic        serial_in_out,  // Data pin drive
    input wire logic        serial_in_oe_n, // Data drive enable
    input wire logic        serial_out_pin  // Shift clock or tx
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // --------------------------------
    // Bus answers
    // --------------------------------
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
        else $error("error read not zero");

    // --------------------------------
    // Serial pins
    // --------------------------------
    reset_idle_a: assert property ($past(sys_rst) |-> serial_out_pin && serial_in_oe_n)
        else $error("pins not idle after reset");
    clk_low_a: assert property ($fell(serial_out_pin) && !serial_in_oe_n |-> !serial_out_pin [*3] ##1 serial_out_pin)
        else $error("shift clock low phase wrong");
    clk_high_a: assert property ($rose(serial_out_pin) && !serial_in_oe_n |-> serial_out_pin [*3])
        else $error("shift clock high phase wrong");
    data_hold_a: assert property (!serial_out_pin && !serial_in_oe_n |=> serial_out_pin || $stable(serial_in_out))
        else $error("data moved while clock low");
    send_len_a: assert property ($fell(serial_in_oe_n) |-> ##[42:60] $rose(serial_in_oe_n))
        else $error("mode 0 send length wrong");

    // Main scenarios reached
    cover property (pready && pslverr);
    cover property ($fell(serial_in_oe_n));
    cover property ($fell(serial_out_pin) && serial_in_oe_n);
endmodule // uart_core_sva

bind uart_core uart_core_sva u_uart_core_sva (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(serial_in_pin), .serial_in_out(serial_in_out), .serial_in_oe_n(serial_in_oe_n),
    .serial_out_pin(serial_out_pin));
